// *** hdl/wbc_pkg.sv ***
// package for the write buffer controller: widths, codes, register map and carriers
package wbc_pkg;

    // ----------
    // widths and depths
    // ----------
    localparam int WBC_DATA_W   = 32;
    localparam int WBC_RDATA_W  = 36;
    localparam int WBC_LEVELS   = 8;
    localparam int WBC_RB_DEEP  = 16;
    localparam int WBC_CNT_W    = 4;
    localparam int WBC_RB_CNT_W = 5;
    localparam int WBC_BUS_AW   = 4;

    // ----------
    // load control codes and output select codes
    // ----------
    localparam logic [3:0] WBC_LD_SHIFT8  = 4'h8;
    localparam logic [3:0] WBC_LD_SHIFT4A = 4'h9;
    localparam logic [3:0] WBC_LD_SHIFT4E = 4'ha;
    localparam logic [3:0] WBC_LD_SHIFT2A = 4'hb;
    localparam logic [3:0] WBC_LD_SHIFT2C = 4'hc;
    localparam logic [3:0] WBC_LD_SHIFT2E = 4'hd;
    localparam logic [3:0] WBC_LD_SHIFT2G = 4'he;
    localparam logic [3:0] WBC_LD_HOLD    = 4'hf;
    localparam logic [2:0] WBC_SEL_FIRST  = 3'h0;
    localparam logic [2:0] WBC_SEL_LAST   = 3'h7;

    // ----------
    // register map
    // ----------
    localparam logic [3:0] WBC_CTRL_OFS   = 4'h0;
    localparam logic [3:0] WBC_STATUS_OFS = 4'h4;
    localparam int WBC_CTRL_DEPTH_LSB = 0;
    localparam int WBC_CTRL_CMP_BIT   = 2;
    localparam int WBC_ST_ERR_BIT     = 4;
    localparam logic [1:0] WBC_DEPTH_RST  = 2'h3;
    localparam logic       WBC_CMP_RST    = 1'b0;
    localparam logic [3:0] WBC_CNT_RST    = 4'h0;

    // ----------
    // carriers
    // ----------
    typedef struct packed {
        logic [1:0]  tag;
        logic [15:0] addr_hi;
        logic [13:0] addr_lo;
        logic [1:0]  access_type_bits;
    } wbc_addr_s;

    typedef struct packed {
        wbc_addr_s              addr;
        logic [WBC_DATA_W-1:0]  data;
    } wbc_entry_s;

    typedef struct packed {
        logic       buffer_full_flag;
        logic       buffer_empty_flag;
        logic       read_phase_latch;
        logic       write_phase_latch;
        logic       read_error;
        logic       address_match;
        logic [3:0] load_count;
        logic [3:0] select_count;
    } wbc_status_s;

endpackage : wbc_pkg

// *** hdl/wbc_write_buffer_controller.sv ***
// write buffer controller with address/data slices, flush-before-read and read buffer
// Behaviour
// - address entry is 34 bits, three slices
// - slices: high address plus tag, low plus type
// - latch 32 data bits, pass to memory
// - address buffer serves reads and writes
// - flush pending writes before any read
// - optional address compare signals a match
// - report full; processor stalls further writes
// - depth programmable 1 to 8, cascade deeper; no cascade port here, 8 levels at most
// - partitions of 1, 2, 4, 8 levels
// - load counter picks load, select picks output
// - load enable from request and flag terms
// - select enable from phase latch terms
// - read phase latch set and held, reset-qualified
// - write phase latch from read, empty, acknowledge
// - all slices clocked by processor output clock
// - read buffer carries 36-bit data with parity
// - error feedback from correction unit reported
// - read depth reconfigured per refill, 16 or 1
// - four-bit load code, shifts and hold
// - three-bit select routes one of eight
//
// Our own choices: the address map and the address-and-strobe port.
module wbc_write_buffer_controller
    import wbc_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         memory_write_request,
    input  wire wbc_pkg::wbc_addr_s           cpu_write_addr,
    input  wire logic [wbc_pkg::WBC_DATA_W-1:0] cpu_write_data,
    input  wire logic                         memory_read_request,
    input  wire wbc_pkg::wbc_addr_s           cpu_read_addr,
    input  wire logic                         icache_refill,
    input  wire logic                         write_acknowledge,
    input  wire logic                         mem_read_data_valid,
    input  wire logic [wbc_pkg::WBC_RDATA_W-1:0] mem_read_data,
    input  wire logic                         ecc_error,
    input  wire logic [wbc_pkg::WBC_BUS_AW-1:0] bus_addr,
    input  wire logic [31:0]                  bus_wdata,
    input  wire logic                         bus_write,
    input  wire logic                         bus_read,
    output logic [31:0]                       bus_rdata_reg,
    output wbc_pkg::wbc_addr_s                mem_addr_reg,
    output logic [wbc_pkg::WBC_DATA_W-1:0]    mem_data_reg,
    output logic                              mem_write_valid_reg,
    output logic                              mem_read_valid_reg,
    output logic [wbc_pkg::WBC_RDATA_W-1:0]   cpu_read_data_reg,
    output logic                              cpu_read_valid_reg,
    output logic                              buffer_full_flag_reg,
    output logic                              buffer_empty_flag_reg,
    output logic                              buffer_clock_enable_reg,
    output logic                              load_counter_enable_reg,
    output logic                              select_counter_enable_reg,
    output logic [3:0]                        load_control_code_reg,
    output logic [2:0]                        output_select_code_reg,
    output logic                              address_match_reg,
    output logic                              read_error_reg
);
    import wbc_pkg::*;

    // ----------
    // functions
    // ----------
    // mask of the counter bits that index a level, for depth code d
    function automatic logic [3:0] wbc_low_mask(input logic [1:0] d);
        wbc_low_mask = 4'((1 << d) - 1);
    endfunction : wbc_low_mask

    // the counter bit that marks the second lap round the levels
    function automatic logic wbc_top_bit(input logic [3:0] c, input logic [1:0] d);
        wbc_top_bit = c[d];
    endfunction : wbc_top_bit

    // next counter value, wrapping at twice the programmed depth
    function automatic logic [3:0] wbc_bump(input logic [3:0] c, input logic [1:0] d);
        logic [3:0] wrap;
        wrap     = 4'((2 << d) - 1);
        wbc_bump = (c + 4'h1) & wrap;
    endfunction : wbc_bump

    // does load code ld write register i, and from where
    // returns 0 none, 1 from input, 2 from register i-1
    function automatic logic [1:0] wbc_load_src(input logic [3:0] ld, input int i);
        int first;
        int last;
        first = 0;
        last  = -1;
        unique case (ld)
            WBC_LD_SHIFT8:  begin first = 0; last = 7; end
            WBC_LD_SHIFT4A: begin first = 0; last = 3; end
            WBC_LD_SHIFT4E: begin first = 4; last = 7; end
            WBC_LD_SHIFT2A: begin first = 0; last = 1; end
            WBC_LD_SHIFT2C: begin first = 2; last = 3; end
            WBC_LD_SHIFT2E: begin first = 4; last = 5; end
            WBC_LD_SHIFT2G: begin first = 6; last = 7; end
            WBC_LD_HOLD:    begin first = 0; last = -1; end
            default:        begin first = int'(ld[2:0]); last = int'(ld[2:0]); end
        endcase
        if (i == first && i <= last) begin
            wbc_load_src = 2'h1;
        end else if (i > first && i <= last) begin
            wbc_load_src = 2'h2;
        end else begin
            wbc_load_src = 2'h0;
        end
    endfunction : wbc_load_src

    // ----------
    // register file: control and status
    // ----------
    logic [1:0]  depth_reg, depth_next;
    logic        cmp_en_reg, cmp_en_next;
    logic [31:0] rdata_next;
    wbc_status_s status;

    // depth is meant to change only while the buffer is empty
    always_comb begin
        depth_next  = depth_reg;
        cmp_en_next = cmp_en_reg;
        rdata_next  = 32'h0;
        if (bus_write && bus_addr == WBC_CTRL_OFS) begin
            depth_next  = bus_wdata[WBC_CTRL_DEPTH_LSB +: 2];
            cmp_en_next = bus_wdata[WBC_CTRL_CMP_BIT];
        end
        if (bus_read) begin
            unique case (bus_addr)
                WBC_CTRL_OFS:   rdata_next = {29'h0, cmp_en_reg, depth_reg};
                WBC_STATUS_OFS: rdata_next = {18'h0, status};
                default:        rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            depth_reg     <= WBC_DEPTH_RST;
            cmp_en_reg    <= WBC_CMP_RST;
            bus_rdata_reg <= 32'h0;
        end else begin
            depth_reg     <= depth_next;
            cmp_en_reg    <= cmp_en_next;
            bus_rdata_reg <= rdata_next;
        end
    end

    // ----------
    // counters, flags and phase latches
    // ----------
    logic [3:0] lc_reg, lc_next, sc_reg, sc_next;
    logic       rd_phase_reg, rd_phase_next, wr_phase_reg, wr_phase_next;
    logic       full, empty, top_mismatch, low_equal;
    logic       load_en, sel_en, wr_load, rd_load, empty_next;
    logic [3:0] load_code;
    logic [3:0] mask;

    // flags from the two counters; the top bit tells full from empty
    always_comb begin
        mask         = wbc_low_mask(depth_reg);
        low_equal    = ((lc_reg ^ sc_reg) & mask) == 4'h0;
        top_mismatch = wbc_top_bit(lc_reg, depth_reg) ^ wbc_top_bit(sc_reg, depth_reg);
        full         = low_equal && top_mismatch;
        empty        = low_equal && !top_mismatch;
    end

    // a write is taken only when not full and no read is pending;
    // a read address is queued only once every write has drained
    always_comb begin
        wr_load   = memory_write_request && !full && !memory_read_request && !rd_phase_reg;
        rd_load   = memory_read_request && empty && !wr_phase_reg && !rd_phase_reg;
        load_en   = wr_load || rd_load;
        sel_en    = (wr_phase_reg && write_acknowledge)
                  || (rd_phase_reg && !memory_read_request);
        lc_next   = load_en ? wbc_bump(lc_reg, depth_reg) : lc_reg;
        sc_next   = sel_en ? wbc_bump(sc_reg, depth_reg) : sc_reg;
        load_code = load_en ? {1'b0, lc_reg[2:0] & mask[2:0]} : WBC_LD_HOLD;
        empty_next = (((lc_next ^ sc_next) & mask) == 4'h0)
                  && (wbc_top_bit(lc_next, depth_reg) == wbc_top_bit(sc_next, depth_reg));
        rd_phase_next = !reset && (rd_load
                      || (rd_phase_reg && memory_read_request));
        wr_phase_next = !reset && !rd_phase_reg && !rd_phase_next
                      && !empty_next;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lc_reg       <= WBC_CNT_RST;
            sc_reg       <= WBC_CNT_RST;
            rd_phase_reg <= 1'b0;
            wr_phase_reg <= 1'b0;
        end else begin
            lc_reg       <= lc_next;
            sc_reg       <= sc_next;
            rd_phase_reg <= rd_phase_next;
            wr_phase_reg <= wr_phase_next;
        end
    end

    // ----------
    // pipeline register slices: address (three slices) and data
    // ----------
    wbc_entry_s entry_reg [WBC_LEVELS];
    wbc_entry_s entry_next [WBC_LEVELS];
    wbc_entry_s load_value;
    logic [2:0] out_sel;

    // read entries carry no data; the address slice serves both
    always_comb begin
        load_value.addr = rd_load ? cpu_read_addr : cpu_write_addr;
        load_value.data = rd_load ? '0 : cpu_write_data;
        out_sel         = sc_next[2:0] & mask[2:0];
    end

    generate
        for (genvar i = 0; i < WBC_LEVELS; i++) begin : g_level
            // each level follows the decoded load code
            always_comb begin
                unique case (wbc_load_src(load_code, i))
                    2'h1:    entry_next[i] = load_value;
                    2'h2:    entry_next[i] = entry_reg[(i + 7) % 8];
                    default: entry_next[i] = entry_reg[i];
                endcase
            end

            // all slices run from the one processor-side clock
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    entry_reg[i] <= '0;
                end else begin
                    entry_reg[i] <= entry_next[i];
                end
            end
        end
    endgenerate

    // ----------
    // optional conflict compare against queued write addresses
    // ----------
    logic       match_next;
    logic [3:0] pending;
    logic [3:0] age;

    // flushing still happens; the match only informs the processor
    always_comb begin
        pending    = (lc_reg - sc_reg) & 4'((2 << depth_reg) - 1);
        match_next = 1'b0;
        age        = 4'h0;
        for (int i = 0; i < WBC_LEVELS; i++) begin
            age = (4'(i) - sc_reg) & mask;
            if (cmp_en_reg && memory_read_request && !rd_phase_reg && age < pending
                && entry_reg[i].addr.addr_hi == cpu_read_addr.addr_hi
                && entry_reg[i].addr.addr_lo == cpu_read_addr.addr_lo) begin
                match_next = 1'b1;
            end
        end
    end

    // ----------
    // read buffer: 36-bit words, depth 16 or 1 chosen per refill
    // ----------
    logic [WBC_RDATA_W-1:0]  rb_reg [WBC_RB_DEEP];
    logic [WBC_RB_CNT_W-1:0] rb_wr_reg, rb_wr_next, rb_rd_reg, rb_rd_next;
    logic [WBC_RB_CNT_W-1:0] rb_lim_reg, rb_lim_next;
    logic                    rb_take, rb_give, err_next;

    // words beyond the chosen depth are dropped, not wrapped
    always_comb begin
        rb_lim_next = rd_load ? (icache_refill ? 5'(WBC_RB_DEEP) : 5'h1) : rb_lim_reg;
        rb_take     = mem_read_data_valid && rd_phase_reg && rb_wr_reg < rb_lim_reg;
        rb_give     = rb_rd_reg < rb_wr_reg;
        rb_wr_next  = rd_load ? 5'h0 : (rb_take ? rb_wr_reg + 5'h1 : rb_wr_reg);
        rb_rd_next  = rd_load ? 5'h0 : (rb_give ? rb_rd_reg + 5'h1 : rb_rd_reg);
        // a new error beats a clear in the same cycle
        err_next    = (ecc_error && rd_phase_reg)
                    || (read_error_reg && !(bus_write && bus_addr == WBC_STATUS_OFS
                                            && bus_wdata[WBC_ST_ERR_BIT]));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rb_wr_reg  <= 5'h0;
            rb_rd_reg  <= 5'h0;
            rb_lim_reg <= 5'h1;
        end else begin
            rb_wr_reg  <= rb_wr_next;
            rb_rd_reg  <= rb_rd_next;
            rb_lim_reg <= rb_lim_next;
            if (rb_take) begin
                rb_reg[rb_wr_reg[3:0]] <= mem_read_data;
            end
        end
    end

    // ----------
    // registered outputs
    // ----------
    always_comb begin
        status.buffer_full_flag  = full;
        status.buffer_empty_flag = empty;
        status.read_phase_latch  = rd_phase_reg;
        status.write_phase_latch = wr_phase_reg;
        status.read_error        = read_error_reg;
        status.address_match     = address_match_reg;
        status.load_count        = lc_reg;
        status.select_count      = sc_reg;
    end

    // outputs show the state after this edge, so memory sees the next entry
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_addr_reg              <= '0;
            mem_data_reg              <= '0;
            mem_write_valid_reg       <= 1'b0;
            mem_read_valid_reg        <= 1'b0;
            cpu_read_data_reg         <= '0;
            cpu_read_valid_reg        <= 1'b0;
            buffer_full_flag_reg      <= 1'b0;
            buffer_empty_flag_reg     <= 1'b1;
            buffer_clock_enable_reg   <= 1'b1;
            load_counter_enable_reg   <= 1'b0;
            select_counter_enable_reg <= 1'b0;
            load_control_code_reg     <= WBC_LD_HOLD;
            output_select_code_reg    <= WBC_SEL_FIRST;
            address_match_reg         <= 1'b0;
            read_error_reg            <= 1'b0;
        end else begin
            mem_addr_reg              <= entry_next[out_sel].addr;
            mem_data_reg              <= entry_next[out_sel].data;
            mem_write_valid_reg       <= wr_phase_next;
            mem_read_valid_reg        <= rd_phase_next;
            cpu_read_data_reg         <= rb_give ? rb_reg[rb_rd_reg[3:0]] : cpu_read_data_reg;
            cpu_read_valid_reg        <= rb_give;
            buffer_full_flag_reg      <= (((lc_next ^ sc_next) & mask) == 4'h0) && !empty_next;
            buffer_empty_flag_reg     <= empty_next;
            buffer_clock_enable_reg   <= empty_next || (((lc_next ^ sc_next) & mask) != 4'h0);
            load_counter_enable_reg   <= load_en;
            select_counter_enable_reg <= sel_en;
            load_control_code_reg     <= load_code;
            output_select_code_reg    <= out_sel;
            address_match_reg         <= match_next;
            read_error_reg            <= err_next;
        end
    end

endmodule : wbc_write_buffer_controller

// *** verif/wbc_properties.sv ***
// concurrent checks on the write buffer controller ports
module wbc_properties
    import wbc_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   reset,
    input wire logic                   memory_write_request,
    input wire logic                   memory_read_request,
    input wire wbc_pkg::wbc_addr_s     cpu_read_addr,
    input wire logic                   write_acknowledge,
    input wire logic                   mem_read_data_valid,
    input wire logic [WBC_RDATA_W-1:0] mem_read_data,
    input wire logic                   ecc_error,
    input wire wbc_pkg::wbc_addr_s     mem_addr_reg,
    input wire logic                   mem_write_valid_reg,
    input wire logic                   mem_read_valid_reg,
    input wire logic [WBC_RDATA_W-1:0] cpu_read_data_reg,
    input wire logic                   cpu_read_valid_reg,
    input wire logic                   buffer_full_flag_reg,
    input wire logic                   buffer_empty_flag_reg,
    input wire logic                   buffer_clock_enable_reg,
    input wire logic                   select_counter_enable_reg,
    input wire logic                   address_match_reg,
    input wire logic                   read_error_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // one clock domain, reset disables all checks
    // ----------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    full_empty_excl_a: assert property (!(buffer_full_flag_reg && buffer_empty_flag_reg))
        else $error("full and empty at once");
    clock_enable_a: assert property (buffer_clock_enable_reg == !buffer_full_flag_reg)
        else $error("clock enable not the inverse of full");
    flush_first_a: assert property ($rose(mem_read_valid_reg)
        |-> $past(buffer_empty_flag_reg) && !$past(mem_write_valid_reg))
        else $error("read started with writes pending");
    write_accept_a: assert property (memory_write_request && !buffer_full_flag_reg && !memory_read_request
        && !mem_read_valid_reg |=> !buffer_empty_flag_reg && mem_write_valid_reg) else $error("write not taken");
    read_answer_a: assert property (memory_read_request && buffer_empty_flag_reg && !mem_write_valid_reg
        && !mem_read_valid_reg |=> mem_read_valid_reg && mem_addr_reg == $past(cpu_read_addr))
        else $error("read address not presented");
    read_word_a: assert property (cpu_read_valid_reg |-> $past(mem_read_data_valid, 2)
        && cpu_read_data_reg == $past(mem_read_data, 2)) else $error("read word not passed");
    full_stall_a: assert property (buffer_full_flag_reg && !write_acknowledge |=> buffer_full_flag_reg)
        else $error("full dropped without retire");
    select_enable_a: assert property (mem_write_valid_reg && write_acknowledge |=> select_counter_enable_reg)
        else $error("select enable missing after retire");
    error_sticky_a: assert property (mem_read_valid_reg && ecc_error |=> read_error_reg)
        else $error("error feedback lost");

    // main scenarios reached
    cover property (buffer_full_flag_reg);
    cover property ($rose(mem_read_valid_reg));
    cover property (address_match_reg);
    cover property ($rose(read_error_reg));
endmodule : wbc_properties

bind wbc_write_buffer_controller wbc_properties u_prop (.sys_clk, .reset, .memory_write_request,
    .memory_read_request, .cpu_read_addr, .write_acknowledge, .mem_read_data_valid, .mem_read_data, .ecc_error,
    .mem_addr_reg, .mem_write_valid_reg, .mem_read_valid_reg, .cpu_read_data_reg, .cpu_read_valid_reg,
    .buffer_full_flag_reg, .buffer_empty_flag_reg, .buffer_clock_enable_reg, .select_counter_enable_reg,
    .address_match_reg, .read_error_reg);

// *** verif/wbc_mem_model.sv ***
// memory side partner: retires writes, returns two words per read
module wbc_mem_model
    import wbc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   stall,
    input  wire logic                   mem_write_valid_reg,
    input  wire logic                   mem_read_valid_reg,
    output logic                        write_acknowledge,
    output logic                        mem_read_data_valid,
    output logic [WBC_RDATA_W-1:0]      mem_read_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       slow_reg;
    logic [2:0] word_reg;
    logic       send;
    // a word only every other cycle, and only two of them
    assign send = mem_read_valid_reg && word_reg < 3'h2 && !mem_read_data_valid;
    // slow_reg spaces acks out; idle data lines toggle so stale values never look valid
    always_ff @(posedge sys_clk) begin
        slow_reg <= reset ? 1'b0 : !slow_reg;
        write_acknowledge <= !reset && mem_write_valid_reg && !stall && !write_acknowledge && slow_reg;
        mem_read_data_valid <= !reset && send;
        mem_read_data <= reset ? '0 : (send ? {4'h5, 29'h0, word_reg} : ~mem_read_data);
        if (reset || !mem_read_valid_reg) word_reg <= 3'h0;
        else if (mem_read_data_valid) word_reg <= word_reg + 3'h1;
    end
endmodule : wbc_mem_model

// *** verif/write_buffer_controller_tb_top.sv ***
// self-checking bench for the write buffer controller
module write_buffer_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wbc_pkg::*;
    logic sys_clk, reset, memory_write_request, memory_read_request, icache_refill, ecc_error, bus_write, bus_read;
    logic stall, write_acknowledge, mem_read_data_valid, mem_write_valid_reg, mem_read_valid_reg, cpu_read_valid_reg;
    logic buffer_full_flag_reg, buffer_empty_flag_reg, buffer_clock_enable_reg, address_match_reg, read_error_reg;
    logic load_counter_enable_reg, select_counter_enable_reg;
    wbc_addr_s cpu_write_addr, cpu_read_addr, mem_addr_reg;
    logic [31:0] cpu_write_data, bus_wdata, bus_rdata_reg, mem_data_reg, rd;
    logic [3:0] bus_addr, load_control_code_reg;
    logic [2:0] output_select_code_reg;
    logic [WBC_RDATA_W-1:0] mem_read_data, cpu_read_data_reg;
    logic [15:0] lfsr_reg;
    wbc_entry_s exp_q[$];
    wbc_entry_s ent;
    int n_fail, n_tests, n_words;

    wbc_write_buffer_controller uut (.sys_clk, .reset, .memory_write_request, .cpu_write_addr, .cpu_write_data,
        .memory_read_request, .cpu_read_addr, .icache_refill, .write_acknowledge, .mem_read_data_valid,
        .mem_read_data, .ecc_error, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata_reg, .mem_addr_reg,
        .mem_data_reg, .mem_write_valid_reg, .mem_read_valid_reg, .cpu_read_data_reg, .cpu_read_valid_reg,
        .buffer_full_flag_reg, .buffer_empty_flag_reg, .buffer_clock_enable_reg, .load_counter_enable_reg,
        .select_counter_enable_reg, .load_control_code_reg, .output_select_code_reg, .address_match_reg,
        .read_error_reg);
    wbc_mem_model u_mem (.sys_clk, .reset, .stall, .mem_write_valid_reg, .mem_read_valid_reg,
        .write_acknowledge, .mem_read_data_valid, .mem_read_data);

    // ----------
    // clock, helpers
    // ----------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk) {bus_write, bus_addr, bus_wdata} <= {1'b1, a, d};
        @(posedge sys_clk) bus_write <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a);
        @(posedge sys_clk) {bus_read, bus_addr} <= {1'b1, a};
        @(posedge sys_clk) bus_read <= 1'b0;
        #1 rd = bus_rdata_reg;
    endtask : bus_rd
    // bounded wait on one of: 0 full, 1 empty, 2 read phase, 3 match
    task automatic wait_on(input int k);
        logic [3:0] w;
        repeat (200) begin
            w = {address_match_reg, mem_read_valid_reg, buffer_empty_flag_reg, buffer_full_flag_reg};
            if (w[k] === 1'b1) return;
            @(posedge sys_clk) #1;
        end
        chk("wait", 1'b1, 1'b0);
        report_and_stop();
    endtask : wait_on
    // back-to-back random writes, one per edge
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            lfsr_reg = lfsr_next(lfsr_reg);
            exp_q.push_back('{addr: '{2'h2, lfsr_reg, ~lfsr_reg[13:0], lfsr_reg[1:0]}, data: {lfsr_reg, ~lfsr_reg}});
            @(posedge sys_clk) {memory_write_request, cpu_write_addr, cpu_write_data} <= {1'b1, exp_q[$]};
        end
        @(posedge sys_clk) memory_write_request <= 1'b0;
        #1;
    endtask : push

    // retired entries leave in order
    always @(posedge sys_clk) if (!reset && write_acknowledge === 1'b1) begin
        ent = exp_q.pop_front();
        chk("waddr", ent.addr, mem_addr_reg);
        chk("wdata", ent.data, mem_data_reg);
    end
    always @(posedge sys_clk) if (cpu_read_valid_reg === 1'b1) begin
        chk("rword", {4'h5, 29'h0, n_words[2:0]}, cpu_read_data_reg);
        n_words++;
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        {memory_write_request, memory_read_request, icache_refill, ecc_error, bus_write, bus_read, stall} = '0;
        {cpu_write_addr, cpu_read_addr, cpu_write_data, bus_wdata, bus_addr} = '0;
        {n_fail, n_tests, n_words} = '0;
        lfsr_reg = 16'h000d;
        reset = 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk("empty", 1'b1, buffer_empty_flag_reg);
        chk("clken", 1'b1, buffer_clock_enable_reg);
        chk("ldcode", WBC_LD_HOLD, load_control_code_reg);
        bus_rd(WBC_CTRL_OFS);
        chk("ctrl", {WBC_CMP_RST, WBC_DEPTH_RST}, rd);
        bus_rd(4'h8);
        chk("unmapped", 36'h0, rd);
        // every depth code: fill to full, try one refused write, then drain
        for (int d = 0; d < 4; d++) begin
            bus_wr(WBC_CTRL_OFS, d);
            stall <= 1'b1;
            push(1 << d);
            chk("full", 1'b1, buffer_full_flag_reg);
            @(posedge sys_clk) memory_write_request <= 1'b1;
            @(posedge sys_clk) memory_write_request <= 1'b0;
            bus_rd(WBC_STATUS_OFS);
            chk("st_full", 2'h2, rd[13:12]);
            stall <= 1'b0;
            wait_on(1);
            chk("drained", 1'b0, exp_q.size() != 0);
        end
        // reads behind a pending write: match, flush, words, error feedback
        bus_wr(WBC_CTRL_OFS, 32'h7);
        for (int r = 0; r < 2; r++) begin
            icache_refill <= r[0];
            stall <= 1'b1;
            push(1);
            {memory_read_request, cpu_read_addr} <= {1'b1, exp_q[0].addr};
            wait_on(3);
            stall <= 1'b0;
            wait_on(2);
            n_words = 0;
            @(posedge sys_clk) ecc_error <= 1'b1;
            @(posedge sys_clk) ecc_error <= 1'b0;
            repeat (8) @(posedge sys_clk);
            memory_read_request <= 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 chk("words", r + 1, n_words);
            bus_rd(WBC_STATUS_OFS);
            chk("err", 1'b1, rd[9]);
            bus_wr(WBC_STATUS_OFS, 32'h10);
            bus_rd(WBC_STATUS_OFS);
            chk("errclr", 1'b0, rd[9]);
        end
        report_and_stop();
    end
endmodule : write_buffer_controller_tb_top
